// ===== rtl/dtr_pkg.sv
// Constants, types and register map of the distributor integration test status bank
package dtr_pkg;

	localparam int          CPU_COUNT        = 8;
	localparam int          CPU_IDX_W        = 3;
	localparam int          DIST_IDENT_WIDTH = 8;
	localparam int          ADDR_W           = 12;
	localparam int          DATA_W           = 32;

	// Offsets within the block window, the base is decoded outside
	localparam logic [11:0] LEGACY_BYPASS_STATUS_OFS  = 12'hDD4;
	localparam logic [11:0] CPU_MATCH_TIE_STATUS_OFS  = 12'hDE0;
	localparam logic [11:0] CPU_SELECT_TIE_STATUS_OFS = 12'hDE4;

	// Field positions in the legacy bypass status word
	localparam int          LEGACY_IRQ_BIT  = 0;
	localparam int          LEGACY_FIQ_BIT  = 1;
	localparam int          CFG_LOCK_BIT    = 2;

	// Which interfaces actually have legacy bypass inputs
	localparam logic [7:0]  LEGACY_IRQ_PRESENT = 8'hFF;
	localparam logic [7:0]  LEGACY_FIQ_PRESENT = 8'hFF;

	// Bits of the match and select vectors that exist
	localparam logic [31:0] IDENT_MASK = 32'hFFFFFFFF >> (DATA_W - DIST_IDENT_WIDTH);

	localparam logic [31:0] RESET_WORD = 32'h00000000;

	// Access size encoding
	localparam logic [1:0]  SIZE_BYTE = 2'h0;
	localparam logic [1:0]  SIZE_HALF = 2'h1;
	localparam logic [1:0]  SIZE_WORD = 2'h2;

	localparam int          SYNC_W = 2 * CPU_COUNT + 1 + 2 * CPU_COUNT * DATA_W;

	typedef struct packed {
		logic                 sel;
		logic                 write;
		logic                 secure;
		logic [1:0]           size;
		logic [CPU_IDX_W-1:0] cpu;
		logic [ADDR_W-1:0]    addr;
		logic [DATA_W-1:0]    wdata;
	} dtr_req_type;

	typedef struct packed {
		logic              ack;
		logic [DATA_W-1:0] rdata;
	} dtr_rsp_type;

	typedef struct packed {
		dtr_rsp_type rsp;
	} dtr_state_type;

endpackage : dtr_pkg

// ===== rtl/dtr_status_regs.sv
// Distributor integration test status registers behind the register port
`timescale 1ns/1ps
module dtr_status_regs (
	input  wire logic                                     ref_clk_i,
	input  wire logic                                     rst_n_i,
	input  wire dtr_pkg::dtr_req_type                     req_i,
	input  wire logic [dtr_pkg::CPU_COUNT-1:0]            legacy_irq_i,
	input  wire logic [dtr_pkg::CPU_COUNT-1:0]            legacy_fiq_i,
	input  wire logic                                     cfg_lock_i,
	input  wire logic [dtr_pkg::CPU_COUNT-1:0][31:0]      match_tie_i,
	input  wire logic [dtr_pkg::CPU_COUNT-1:0][31:0]      select_tie_i,
	output dtr_pkg::dtr_rsp_type                          rsp_o
);

	// Synchronised copies of the pin and tie-off levels
	logic [dtr_pkg::SYNC_W-1:0]                 sync_q;
	logic [dtr_pkg::CPU_COUNT-1:0]              irq_s;
	logic [dtr_pkg::CPU_COUNT-1:0]              fiq_s;
	logic                                       lock_s;
	logic [dtr_pkg::CPU_COUNT-1:0][31:0]        match_s;
	logic [dtr_pkg::CPU_COUNT-1:0][31:0]        select_s;

	// Decode of the access presented this cycle
	logic                                       rd_ok;
	logic                                       hit_legacy;
	logic                                       hit_match;
	logic                                       hit_select;

	// Banked register images, one set per interface
	logic [dtr_pkg::CPU_COUNT-1:0][31:0]        legacy_img;
	logic [dtr_pkg::CPU_COUNT-1:0][31:0]        match_img;
	logic [dtr_pkg::CPU_COUNT-1:0][31:0]        select_img;

	// Images of the interface that the access addresses
	logic [31:0]                                legacy_bank;
	logic [31:0]                                match_bank;
	logic [31:0]                                select_bank;

	// Register word before lane masking, and the lanes the access covers
	logic [31:0]                                raw_word;
	logic [3:0]                                 lanes;
	logic [31:0]                                lane_mask;

	// Registered response, the only state of this module
	dtr_pkg::dtr_state_type                     st;
	dtr_pkg::dtr_state_type                     next_st;

	// Tie-offs are static, but syncing them too keeps every pin on one rule
	dtr_sync #(
		.W (dtr_pkg::SYNC_W)
	) u_sync (
		.ref_clk_i (ref_clk_i),
		.rst_n_i   (rst_n_i),
		.d_i       ({legacy_irq_i, legacy_fiq_i, cfg_lock_i, match_tie_i, select_tie_i}),
		.q_o       (sync_q)
	);

	assign {irq_s, fiq_s, lock_s, match_s, select_s} = sync_q;

	// Only secure reads carry data; writes and open-state reads answer zero
	assign rd_ok = req_i.sel && !req_i.write && req_i.secure;

	// Word-aligned offset compare; the system base is stripped before this port
	always_comb begin
		hit_legacy = 1'b0;
		hit_match  = 1'b0;
		hit_select = 1'b0;
		if (req_i.addr[11:2] == dtr_pkg::LEGACY_BYPASS_STATUS_OFS[11:2]) begin
			hit_legacy = 1'b1;
		end
		// A single interface has no match or select register to offer
		if (dtr_pkg::CPU_COUNT >= 2) begin
			if (req_i.addr[11:2] == dtr_pkg::CPU_MATCH_TIE_STATUS_OFS[11:2]) begin
				hit_match = 1'b1;
			end
			if (req_i.addr[11:2] == dtr_pkg::CPU_SELECT_TIE_STATUS_OFS[11:2]) begin
				hit_select = 1'b1;
			end
		end
	end

	// Legacy images: the lock tie-off is shared, bypass levels are per interface
	always_comb begin
		for (int i = 0; i < dtr_pkg::CPU_COUNT; i++) begin
			legacy_img[i]                          = dtr_pkg::RESET_WORD;
			legacy_img[i][dtr_pkg::CFG_LOCK_BIT]   = lock_s;
			// Inputs that an interface lacks read as zero through the present masks
			legacy_img[i][dtr_pkg::LEGACY_FIQ_BIT] = fiq_s[i]
				& dtr_pkg::LEGACY_FIQ_PRESENT[i];
			legacy_img[i][dtr_pkg::LEGACY_IRQ_BIT] = irq_s[i]
				& dtr_pkg::LEGACY_IRQ_PRESENT[i];
		end
	end

	// Match images; bits above the identifier width read zero
	always_comb begin
		for (int i = 0; i < dtr_pkg::CPU_COUNT; i++) begin
			match_img[i] = match_s[i] & dtr_pkg::IDENT_MASK;
		end
	end

	// Select images; bits above the identifier width read zero
	always_comb begin
		for (int i = 0; i < dtr_pkg::CPU_COUNT; i++) begin
			select_img[i] = select_s[i] & dtr_pkg::IDENT_MASK;
		end
	end

	// Legacy image of the addressed interface; an index beyond the count reads zero
	always_comb begin
		legacy_bank = dtr_pkg::RESET_WORD;
		for (int i = 0; i < dtr_pkg::CPU_COUNT; i++) begin
			if (int'(req_i.cpu) == i) begin
				legacy_bank = legacy_img[i];
			end
		end
	end

	// Match image of the addressed interface
	always_comb begin
		match_bank = dtr_pkg::RESET_WORD;
		for (int i = 0; i < dtr_pkg::CPU_COUNT; i++) begin
			if (int'(req_i.cpu) == i) begin
				match_bank = match_img[i];
			end
		end
	end

	// Select image of the addressed interface
	always_comb begin
		select_bank = dtr_pkg::RESET_WORD;
		for (int i = 0; i < dtr_pkg::CPU_COUNT; i++) begin
			if (int'(req_i.cpu) == i) begin
				select_bank = select_img[i];
			end
		end
	end

	// Addressed register, gated by the secure read check
	always_comb begin
		raw_word = dtr_pkg::RESET_WORD;
		// Writes, open-state reads and unmapped offsets keep the zero word
		if (rd_ok) begin
			if (hit_legacy) begin
				raw_word = legacy_bank;
			end else if (hit_match) begin
				raw_word = match_bank;
			end else if (hit_select) begin
				raw_word = select_bank;
			end
		end
	end

	// Lanes covered by the access; size code 3 is taken as a word
	always_comb begin
		lanes = 4'hF;
		case (req_i.size)
			dtr_pkg::SIZE_BYTE: begin
				case (req_i.addr[1:0])
					2'h0: begin
						lanes = 4'h1;
					end
					2'h1: begin
						lanes = 4'h2;
					end
					2'h2: begin
						lanes = 4'h4;
					end
					default: begin
						lanes = 4'h8;
					end
				endcase
			end
			dtr_pkg::SIZE_HALF: begin
				// The lowest address bit plays no part in a halfword access
				case (req_i.addr[1])
					1'b0: begin
						lanes = 4'h3;
					end
					default: begin
						lanes = 4'hC;
					end
				endcase
			end
			default: begin
				lanes = 4'hF;
			end
		endcase
	end

	// Little-endian only: byte n of the word always travels on lane n
	always_comb begin
		lane_mask = dtr_pkg::RESET_WORD;
		for (int b = 0; b < 4; b++) begin
			// No swap option exists, so the lane index is the byte index
			if (lanes[b]) begin
				lane_mask[b*8 +: 8] = 8'hFF;
			end
		end
	end

	// Every request is answered on the next edge
	always_comb begin
		next_st           = st;
		next_st.rsp.ack   = req_i.sel;
		// Idle cycles return zero so the data bus does not hold stale values
		next_st.rsp.rdata = raw_word & lane_mask;
	end

	// Response register; cleared on reset
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign rsp_o = st.rsp;

endmodule : dtr_status_regs

// ===== rtl/dtr_sync.sv
// Two-stage level synchroniser for a vector of pin levels
`timescale 1ns/1ps
module dtr_sync #(
	parameter int W = 1
) (
	input  wire logic         ref_clk_i,
	input  wire logic         rst_n_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);

	typedef struct packed {
		logic [W-1:0] first;
		logic [W-1:0] second;
	} dtr_sync_state_type;

	dtr_sync_state_type st;
	dtr_sync_state_type next_st;

	// First stage only feeds the second, nothing else looks at it
	always_comb begin
		next_st        = st;
		next_st.first  = d_i;
		next_st.second = st.first;
	end

	// Clears to zero so reads right after reset show zero
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign q_o = st.second;

endmodule : dtr_sync

// ===== tb/dtr_status_regs_bench.sv
// Bench for the test status bank
`timescale 1ns/1ps
module dtr_status_regs_bench;
	logic                 ref_clk_i = 1'b0;
	logic                 rst_n_i = 1'b0;
	logic                 cfg_lock_i = 1'b0;
	logic [7:0]           legacy_irq_i = 8'h00;
	logic [7:0]           legacy_fiq_i = 8'h00;
	logic [7:0][31:0]     match_tie_i = '0;
	logic [7:0][31:0]     select_tie_i = '0;
	dtr_pkg::dtr_req_type req_i = '0;
	dtr_pkg::dtr_rsp_type rsp_o;
	int                   mismatches = 0;
	int                   tests_run = 0;
	// Free-running clock
	always #5 ref_clk_i = ~ref_clk_i;
	dtr_status_regs dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .req_i(req_i),
		.legacy_irq_i(legacy_irq_i), .legacy_fiq_i(legacy_fiq_i), .cfg_lock_i(cfg_lock_i),
		.match_tie_i(match_tie_i), .select_tie_i(select_tie_i), .rsp_o(rsp_o));
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %0t got %h exp %h", $time, g, e);
		end
	endtask : cmp
	// One access; the answer is judged just after the edge that registers the request
	task automatic acc(input logic [2:0] c, input logic [1:0] z, input logic [11:0] a,
		input logic w, input logic s, input logic [31:0] e);
		@(posedge ref_clk_i);
		req_i <= '{1'b1, w, s, z, c, a, 32'h00000007};
		@(posedge ref_clk_i);
		req_i.sel <= 1'b0;
		#1;
		cmp(32'(rsp_o.ack), 32'h1);
		cmp(rsp_o.rdata, e);
	endtask : acc
	// Pins settle through two sync stages before they are read
	task automatic t_legacy();
		@(posedge ref_clk_i);
		legacy_irq_i <= 8'h5A;
		legacy_fiq_i <= 8'hC3;
		cfg_lock_i <= 1'b1;
		repeat (3) @(posedge ref_clk_i);
		for (int n = 0; n < 8; n++)
			acc(n[2:0], 2'h2, 12'hDD4, 1'b0, 1'b1,
				{29'h0, 1'b1, legacy_fiq_i[n], legacy_irq_i[n]});
	endtask : t_legacy
	task automatic t_tie();
		@(posedge ref_clk_i);
		for (int n = 0; n < 8; n++) begin
			match_tie_i[n] <= 32'(32'h9E3779B9 * (n + 1));
			select_tie_i[n] <= ~32'(32'h7F4A7C15 * (n + 1));
		end
		repeat (3) @(posedge ref_clk_i);
		for (int n = 0; n < 8; n++) begin
			acc(n[2:0], 2'h2, 12'hDE0, 1'b0, 1'b1, match_tie_i[n] & 32'hFF);
			acc(n[2:0], 2'h2, 12'hDE4, 1'b0, 1'b1, select_tie_i[n] & 32'hFF);
		end
		acc(3'h5, 2'h0, 12'hDE4, 1'b0, 1'b1, select_tie_i[5] & 32'hFF);
		acc(3'h5, 2'h1, 12'hDE6, 1'b0, 1'b1, 32'h0);
	endtask : t_tie
	task automatic t_refuse();
		acc(3'h1, 2'h2, 12'hDD4, 1'b1, 1'b1, 32'h0);
		acc(3'h1, 2'h2, 12'hDD4, 1'b0, 1'b1, {29'h0, 1'b1, legacy_fiq_i[1], legacy_irq_i[1]});
		acc(3'h1, 2'h2, 12'hDE0, 1'b0, 1'b0, 32'h0);
		acc(3'h1, 2'h0, 12'hDD5, 1'b0, 1'b1, 32'h0);
	endtask : t_refuse
	task automatic final_report();
		if (mismatches == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : final_report
	// Main sequence, reads zero pins first to see the cleared state
	initial begin
		repeat (8) @(posedge ref_clk_i);
		cmp(32'(rsp_o.ack), 32'h0);
		cmp(rsp_o.rdata, 32'h0);
		rst_n_i <= 1'b1;
		repeat (2) @(posedge ref_clk_i);
		acc(3'h0, 2'h2, 12'hDD4, 1'b0, 1'b1, 32'h0);
		t_legacy();
		t_tie();
		t_refuse();
		final_report();
	end
	// Hang guard, well past the roughly 80 cycles the run needs
	initial begin
		#20000;
		mismatches++;
		final_report();
	end
endmodule : dtr_status_regs_bench

// ===== tb/dtr_status_regs_chk.sv
// Port checker for the test status bank
`timescale 1ns/1ps
module dtr_status_regs_chk (
	input wire logic                 ref_clk_i,
	input wire logic                 rst_n_i,
	input wire dtr_pkg::dtr_req_type req_i,
	input wire dtr_pkg::dtr_rsp_type rsp_o
);
	logic rd;
	// Secure reads are the only ones that may carry data
	assign rd = req_i.sel & ~req_i.write & req_i.secure;
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_n_i);
	property p_ack; req_i.sel |=> rsp_o.ack; endproperty
	a_ack: assert property (p_ack) else $error("ack");
	property p_idle; !req_i.sel |=> !rsp_o.ack && !rsp_o.rdata; endproperty
	a_idle: assert property (p_idle) else $error("idle");
	property p_wr; req_i.sel && req_i.write |=> !rsp_o.rdata; endproperty
	a_wr: assert property (p_wr) else $error("write");
	property p_ns; req_i.sel && !req_i.secure |=> !rsp_o.rdata; endproperty
	a_ns: assert property (p_ns) else $error("open");
	property p_rsv;
		rd && req_i.addr[11:2] == 10'h375 && req_i.size == 2'h0 && req_i.addr[1:0] != 2'h0
			|=> !rsp_o.rdata;
	endproperty
	a_rsv: assert property (p_rsv) else $error("legacy lane");
	property p_leg; rd && req_i.addr[11:2] == 10'h375 |=> !rsp_o.rdata[31:3]; endproperty
	a_leg: assert property (p_leg) else $error("legacy");
	property p_wid; rd && req_i.addr[11:3] == 9'h1BC |=> !rsp_o.rdata[31:8]; endproperty
	a_wid: assert property (p_wid) else $error("width");
	property p_lane; rd && req_i.size < 2'h2 && req_i.addr[1] |=> !rsp_o.rdata[15:0]; endproperty
	a_lane: assert property (p_lane) else $error("lane");
endmodule : dtr_status_regs_chk
bind dtr_status_regs dtr_status_regs_chk chk (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
	.req_i(req_i), .rsp_o(rsp_o));
